// >>> hdl/lbec_pkg.sv
// Shared constants and types of the LED breathing effect controller
package lbec_pkg;
  // Clock and breathing timebase
  localparam int CLK_HZ = 25_000_000;
  localparam int TAU_MS = 260;
  localparam int FINE_STEPS = 256;
  localparam int FINE_CYC = CLK_HZ / 1000 * TAU_MS / FINE_STEPS;
  // Bus address, value is arbitrary
  localparam logic [6:0] I2C_ADDR = 7'h64;
  // Register offsets
  localparam logic [7:0] A_PD = 8'h00;
  localparam logic [7:0] A_LED1 = 8'h01;
  localparam logic [7:0] A_LED2 = 8'h02;
  localparam logic [7:0] A_CFG1 = 8'h03;
  localparam logic [7:0] A_CFG2 = 8'h04;
  localparam logic [7:0] A_RAMP = 8'h05;
  localparam logic [7:0] A_MARK = 8'h06;
  localparam logic [7:0] A_PWM0 = 8'h07;
  localparam logic [7:0] A_PWM8 = 8'h0f;
  localparam logic [7:0] A_DCOMMIT = 8'h10;
  localparam logic [7:0] A_T0 = 8'h11;
  localparam logic [7:0] A_T0END = 8'h19;
  localparam logic [7:0] A_TR = 8'h1a;
  localparam logic [7:0] A_TREND = 8'h1c;
  localparam logic [7:0] A_T4 = 8'h1d;
  localparam logic [7:0] A_T4END = 8'h25;
  localparam logic [7:0] A_TCOMMIT = 8'h26;
  localparam logic [7:0] A_RESET = 8'hff;
  localparam logic [7:0] COMMIT_VAL = 8'h00;
  // Writable bit masks
  localparam logic [7:0] MSK_PD = 8'h01;
  localparam logic [7:0] MSK_CFG1 = 8'h77;
  localparam logic [7:0] MSK_CFG2 = 8'hf7;
  localparam logic [7:0] MSK_RAMP = 8'h77;
  localparam logic [7:0] MSK_MARK = 8'h1f;
  localparam logic [7:0] MSK_T04 = 8'h3f;
  localparam logic [7:0] MSK_TR = 8'hf7;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [8:0] RST_ON = 9'h1ff;
  // Field positions
  localparam int SSD_BIT = 0;
  localparam int MODE_LSB = 4;
  localparam int AE_BIT = 2;
  localparam int AGCE_BIT = 1;
  localparam int AGCM_BIT = 0;
  localparam int CM_BIT = 7;
  localparam int CS_LSB = 4;
  localparam int AGS_LSB = 0;
  localparam int RM_LSB = 4;
  localparam int HT_LSB = 0;
  localparam int BME_BIT = 4;
  localparam int CSS_LSB = 0;
  localparam logic [3:0] CSS_MAX = 4'h8;
  // Automatic gain control
  localparam logic [11:0] AGC_QUIET = 12'h040;
  localparam logic [2:0] AGC_SLOW_DIV = 3'h7;

  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_DELAY = 6'h02,
    PH_RISE = 6'h04,
    PH_PEAK = 6'h08,
    PH_FALL = 6'h10,
    PH_OFF = 6'h20
  } lbec_phase_t;

  typedef enum logic [6:0] {
    BS_IDLE = 7'h01,
    BS_ADDR = 7'h02,
    BS_ACKA = 7'h04,
    BS_WR = 7'h08,
    BS_ACKW = 7'h10,
    BS_RD = 7'h20,
    BS_ACKR = 7'h40
  } lbec_bus_t;

  // Audio gain in 3 dB steps, x16 fixed point
  function automatic logic [7:0] gain_mul(input logic [2:0] g);
    case (g)
      3'h0: gain_mul = 8'h10;
      3'h1: gain_mul = 8'h17;
      3'h2: gain_mul = 8'h20;
      3'h3: gain_mul = 8'h2d;
      3'h4: gain_mul = 8'h40;
      3'h5: gain_mul = 8'h5b;
      3'h6: gain_mul = 8'h80;
      default: gain_mul = 8'hb5;
    endcase
  endfunction
endpackage

// >>> hdl/lbec_i2c.sv
// Two-wire register bus slave with auto-increment pointer
`timescale 1ns/1ps
`default_nettype none
module lbec_i2c (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic busReset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic wrStb,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData
);
  typedef struct packed {
    logic sc1, sc2, scP, sd1, sd2, sdP;
    lbec_pkg::lbec_bus_t st;
    logic [3:0] bitCnt;
    logic [7:0] sh, ptr, wad, wdat;
    logic haveAddr, rw, nack, oe, wr;
  } lbec_i2c_t;
  lbec_i2c_t r, n;

  always_comb begin
    logic rise, fall;
    rise = 1'b0;
    fall = 1'b0;
    n = r;
    n.wr = 1'b0;
    n.sc1 = sclIn;
    n.sc2 = r.sc1;
    n.scP = r.sc2;
    n.sd1 = sdaIn;
    n.sd2 = r.sd1;
    n.sdP = r.sd2;
    rise = r.sc2 && !r.scP;
    fall = !r.sc2 && r.scP;
    if (rise) begin
      if (r.st == lbec_pkg::BS_ADDR || r.st == lbec_pkg::BS_WR) begin
        n.sh = {r.sh[6:0], r.sd2};
        n.bitCnt = r.bitCnt + 4'h1;
      end
      if (r.st == lbec_pkg::BS_ACKR) n.nack = r.sd2;
    end
    if (fall) begin
      case (r.st)
        lbec_pkg::BS_ADDR: if (r.bitCnt == 4'h8) begin
          n.rw = r.sh[0];
          n.oe = (r.sh[7:1] == lbec_pkg::I2C_ADDR);
          n.st = n.oe ? lbec_pkg::BS_ACKA : lbec_pkg::BS_IDLE;
        end
        lbec_pkg::BS_ACKA, lbec_pkg::BS_ACKR: begin
          n.bitCnt = 4'h1;
          n.sh = {rdData[6:0], 1'b0};
          n.oe = !rdData[7];
          n.st = lbec_pkg::BS_RD;
          if (r.st == lbec_pkg::BS_ACKR && r.nack) begin
            n.oe = 1'b0;
            n.st = lbec_pkg::BS_IDLE;
          end
          if (r.st == lbec_pkg::BS_ACKA && !r.rw) begin
            n.oe = 1'b0;
            n.bitCnt = 4'h0;
            n.haveAddr = 1'b0;
            n.st = lbec_pkg::BS_WR;
          end
        end
        lbec_pkg::BS_WR: if (r.bitCnt == 4'h8) begin
          n.oe = 1'b1;
          n.st = lbec_pkg::BS_ACKW;
          n.haveAddr = 1'b1;
          if (!r.haveAddr) n.ptr = r.sh;
          else begin
            n.wr = 1'b1;
            n.wad = r.ptr;
            n.wdat = r.sh;
            n.ptr = r.ptr + 8'h01;
          end
        end
        lbec_pkg::BS_ACKW: begin
          n.oe = 1'b0;
          n.bitCnt = 4'h0;
          n.st = lbec_pkg::BS_WR;
        end
        lbec_pkg::BS_RD: if (r.bitCnt == 4'h8) begin
          n.oe = 1'b0;
          n.ptr = r.ptr + 8'h01;
          n.st = lbec_pkg::BS_ACKR;
        end else begin
          n.oe = !r.sh[7];
          n.sh = {r.sh[6:0], 1'b0};
          n.bitCnt = r.bitCnt + 4'h1;
        end
        default: n.st = r.st;
      endcase
    end
    // Start and stop conditions
    if (r.sc2 && r.scP && r.sdP && !r.sd2) begin
      n.st = lbec_pkg::BS_ADDR;
      n.bitCnt = 4'h0;
      n.oe = 1'b0;
    end
    if ((r.sc2 && r.scP && !r.sdP && r.sd2) || busReset) begin
      n.st = lbec_pkg::BS_IDLE;
      n.oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.sc1 <= 1'b1;
      r.sc2 <= 1'b1;
      r.scP <= 1'b1;
      r.sd1 <= 1'b1;
      r.sd2 <= 1'b1;
      r.sdP <= 1'b1;
      r.st <= lbec_pkg::BS_IDLE;
    end else begin
      r <= n;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = r.oe;
  assign wrStb = r.wr;
  assign wrAddr = r.wad;
  assign wrData = r.wdat;
  assign rdAddr = r.ptr;
endmodule
`default_nettype wire

// >>> hdl/lbec_breath.sv
// One-channel breathing sequencer through delay, rise, peak, fall and off
`timescale 1ns/1ps
`default_nettype none
module lbec_breath (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [7:0] peak,
  input wire logic [5:0] t0,
  input wire logic [5:0] t4,
  input wire logic [7:0] tr,
  input wire logic rampEn,
  input wire logic holdSel,
  output logic [7:0] level,
  output logic riseEnd,
  output logic fallEnd
);
  typedef struct packed {
    lbec_pkg::lbec_phase_t st;
    logic [15:0] cnt;
    logic [7:0] level;
    logic riseEnd, fallEnd;
  } lbec_br_t;
  lbec_br_t r, n;

  function automatic logic [15:0] ramp_len(input logic [2:0] a);
    ramp_len = (a == 3'h7) ? 16'h0001 : (16'h0100 << a);
  endfunction

  function automatic logic [15:0] mult_len(input logic [5:0] v);
    mult_len = {4'h0, v[3:0], 8'h00} << v[5:4];
  endfunction

  always_comb begin
    logic [15:0] len, prod;
    logic [2:0] sh;
    logic [7:0] prog;
    logic hold, adv, off;
    len = 16'h0000;
    prod = 16'h0000;
    prog = 8'h00;
    hold = 1'b0;
    adv = 1'b0;
    sh = tr[2:0];
    off = (tr[2:0] == 3'h5) || (tr[2:0] == 3'h6);
    if (tr[7] && tr[2:0] != 3'h7) sh = tr[2:0] + 3'h1;
    n = r;
    n.riseEnd = 1'b0;
    n.fallEnd = 1'b0;
    case (r.st)
      lbec_pkg::PH_DELAY: len = mult_len(t0);
      lbec_pkg::PH_RISE: len = ramp_len(tr[2:0]);
      lbec_pkg::PH_PEAK: len = (tr[6:4] == 3'h0) ? 16'h0000 : (16'h0100 << (tr[6:4] - 3'h1));
      lbec_pkg::PH_FALL: len = ramp_len(sh);
      lbec_pkg::PH_OFF: len = mult_len(t4);
      default: len = 16'h0000;
    endcase
    prog = (r.st == lbec_pkg::PH_FALL) ? ~8'(r.cnt >> sh) : 8'(r.cnt >> tr[2:0]);
    if (len == 16'h0001) prog = (r.st == lbec_pkg::PH_FALL) ? 8'hff : 8'h00;
    prod = {8'h00, peak} * {8'h00, prog};
    hold = (r.st == lbec_pkg::PH_PEAK && rampEn && !holdSel) ||
           (r.st == lbec_pkg::PH_OFF && rampEn && holdSel);
    adv = (len == 16'h0000) || (tick && r.cnt == len - 16'h0001);
    if (r.st != lbec_pkg::PH_IDLE && !hold) begin
      if (adv) begin
        n.cnt = 16'h0000;
        case (r.st)
          lbec_pkg::PH_DELAY: n.st = lbec_pkg::PH_RISE;
          lbec_pkg::PH_RISE: n.st = lbec_pkg::PH_PEAK;
          lbec_pkg::PH_PEAK: n.st = lbec_pkg::PH_FALL;
          lbec_pkg::PH_FALL: n.st = lbec_pkg::PH_OFF;
          default: n.st = lbec_pkg::PH_RISE;
        endcase
        n.riseEnd = (r.st == lbec_pkg::PH_RISE);
        n.fallEnd = (r.st == lbec_pkg::PH_FALL);
      end else if (tick) begin
        n.cnt = r.cnt + 16'h0001;
      end
    end
    case (r.st)
      lbec_pkg::PH_RISE, lbec_pkg::PH_FALL: n.level = prod[15:8];
      lbec_pkg::PH_PEAK: n.level = peak;
      default: n.level = 8'h00;
    endcase
    if (start) begin
      n.st = lbec_pkg::PH_DELAY;
      n.cnt = 16'h0000;
    end
    if (stop || off) begin
      n.st = lbec_pkg::PH_IDLE;
      n.cnt = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= lbec_pkg::PH_IDLE;
    end else begin
      r <= n;
    end
  end

  assign level = r.level;
  assign riseEnd = r.riseEnd;
  assign fallEnd = r.fallEnd;
endmodule
`default_nettype wire

// >>> hdl/lbec_top.sv
// Nine-channel LED breathing effect controller, register file and outputs
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mode bit 0: channel duty from register
// - Mode bit 1: group breathes on its own
// - Delay once, then rise, peak, fall, off
// - Duty register sets breathing peak level
// - After shutdown, breathing waits for time commit
// - Ramping needs mode bit and ramp bit
// - Hold select 0 stops at peak
// - Hold select 1 finishes cycle, stays off
// - Gain drops on clipping, rises when quiet
// - Gain control enable bit set uses fixed gain
// - Marker enable picks marker or sync clock
// - Marker falls at end of rise
// - Marker rises at end of fall
// - Marker follows the one selected channel
// - No marker while cascade slave
// - Master drives clock and audio sync pins
// - Registers kept and accessible during shutdown
// - Soft power-down bit 0 turns channels off
// - Power-down pin low turns channels off
// - Duty and on/off applied on data commit
// - Phase times applied on time commit
// - Channel select codes 0 to 8 only
module lbec_top #(
  parameter int FINE_CYC = lbec_pkg::FINE_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic hwPowerDownN,
  input wire logic syncClockOrMarkerPinIn,
  output logic syncClockOrMarkerPinOut,
  output logic syncClockOrMarkerPinOe,
  input wire logic audioCurrentSyncIn,
  output logic audioCurrentSyncOut,
  output logic audioCurrentSyncOe,
  input wire logic [7:0] audioIn,
  output logic [8:0] chanOut,
  output logic [2:0] currentSel
);
  typedef struct packed {
    logic [7:0] pd, cfg1, cfg2, ramp, mark;
    logic [8:0] onSh, onAct;
    logic [8:0][7:0] pwmSh, pwmAct;
    logic [8:0][5:0] t0Sh, t0Act, t4Sh, t4Act;
    logic [2:0][7:0] trSh, trAct;
  } lbec_regs_t;

  typedef struct packed {
    lbec_regs_t regs;
    logic hwS1, hwS2, hwPrev, lkS1, lkS2, lkPrev, auS1, auS2;
    logic [15:0] fineCnt;
    logic fineTick, clkTog, brStart;
    logic [7:0] pwmCnt;
    logic [8:0][7:0] dutyLat;
    logic [8:0] chanOut;
    logic [2:0] gain, agcDiv, currentSel;
    logic [7:0] audLvl;
    logic breathMarkerOut, pinOut, pinOe, audOut, audOe;
  } lbec_top_t;
  lbec_top_t r, n;

  logic wrStb;
  logic [7:0] wrAddr, wrData, rdAddr, rdData;
  logic [8:0][7:0] brLvl;
  logic [8:0] riseEnd, fallEnd;
  logic powered, slave, busReset;

  function automatic lbec_regs_t regs_default();
    lbec_regs_t v;
    v = '0;
    v.pd = lbec_pkg::RST_BYTE;
    v.onSh = lbec_pkg::RST_ON;
    v.onAct = lbec_pkg::RST_ON;
    regs_default = v;
  endfunction

  function automatic logic [7:0] scale(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    p = {8'h00, a} * {8'h00, b};
    scale = p[15:8];
  endfunction

  assign powered = r.regs.pd[lbec_pkg::SSD_BIT] && r.hwS2;
  assign slave = r.regs.cfg2[lbec_pkg::CM_BIT];
  assign busReset = r.hwS2 && !r.hwPrev;

  lbec_i2c u_bus (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .busReset(busReset),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  for (genvar i = 0; i < 9; i++) begin : g_ch
    lbec_breath u_br (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .tick(r.fineTick),
      .start(r.brStart),
      .stop(!powered || !r.regs.cfg1[lbec_pkg::MODE_LSB + i / 3]),
      .peak(r.regs.pwmAct[i]),
      .t0(r.regs.t0Act[i]),
      .t4(r.regs.t4Act[i]),
      .tr(r.regs.trAct[i / 3]),
      .rampEn(r.regs.cfg1[lbec_pkg::MODE_LSB + i / 3] &&
              r.regs.ramp[lbec_pkg::RM_LSB + i / 3]),
      .holdSel(r.regs.ramp[lbec_pkg::HT_LSB + i / 3]),
      .level(brLvl[i]),
      .riseEnd(riseEnd[i]),
      .fallEnd(fallEnd[i])
    );
  end

  // Register readback shows the written values
  always_comb begin
    rdData = 8'h00;
    case (rdAddr)
      lbec_pkg::A_PD: rdData = r.regs.pd;
      lbec_pkg::A_LED1: rdData = {1'b0, r.regs.onSh[5:3], 1'b0, r.regs.onSh[2:0]};
      lbec_pkg::A_LED2: rdData = {5'h00, r.regs.onSh[8:6]};
      lbec_pkg::A_CFG1: rdData = r.regs.cfg1;
      lbec_pkg::A_CFG2: rdData = r.regs.cfg2;
      lbec_pkg::A_RAMP: rdData = r.regs.ramp;
      lbec_pkg::A_MARK: rdData = r.regs.mark;
      default: begin
        if (rdAddr >= lbec_pkg::A_PWM0 && rdAddr <= lbec_pkg::A_PWM8)
          rdData = r.regs.pwmSh[4'(rdAddr - lbec_pkg::A_PWM0)];
        else if (rdAddr >= lbec_pkg::A_T0 && rdAddr <= lbec_pkg::A_T0END)
          rdData = {2'h0, r.regs.t0Sh[4'(rdAddr - lbec_pkg::A_T0)]};
        else if (rdAddr >= lbec_pkg::A_TR && rdAddr <= lbec_pkg::A_TREND)
          rdData = r.regs.trSh[2'(rdAddr - lbec_pkg::A_TR)];
        else if (rdAddr >= lbec_pkg::A_T4 && rdAddr <= lbec_pkg::A_T4END)
          rdData = {2'h0, r.regs.t4Sh[4'(rdAddr - lbec_pkg::A_T4)]};
      end
    endcase
  end

  always_comb begin
    logic [15:0] amp;
    logic [11:0] ampS;
    logic [7:0] d;
    logic [3:0] marker_channel_select;
    amp = 16'h0000;
    ampS = 12'h000;
    d = 8'h00;
    marker_channel_select = 4'h0;
    n = r;
    n.hwS1 = hwPowerDownN;
    n.hwS2 = r.hwS1;
    n.hwPrev = r.hwS2;
    n.lkS1 = syncClockOrMarkerPinIn;
    n.lkS2 = r.lkS1;
    n.lkPrev = r.lkS2;
    n.auS1 = audioCurrentSyncIn;
    n.auS2 = r.auS1;
    // Register writes, accepted in any power state
    n.brStart = 1'b0;
    if (wrStb) begin
      case (wrAddr)
        lbec_pkg::A_PD: n.regs.pd = wrData & lbec_pkg::MSK_PD;
        lbec_pkg::A_LED1: n.regs.onSh[5:0] = {wrData[6:4], wrData[2:0]};
        lbec_pkg::A_LED2: n.regs.onSh[8:6] = wrData[2:0];
        lbec_pkg::A_CFG1: n.regs.cfg1 = wrData & lbec_pkg::MSK_CFG1;
        lbec_pkg::A_CFG2: n.regs.cfg2 = wrData & lbec_pkg::MSK_CFG2;
        lbec_pkg::A_RAMP: n.regs.ramp = wrData & lbec_pkg::MSK_RAMP;
        lbec_pkg::A_MARK: n.regs.mark = wrData & lbec_pkg::MSK_MARK;
        lbec_pkg::A_DCOMMIT: if (wrData == lbec_pkg::COMMIT_VAL) begin
          n.regs.onAct = r.regs.onSh;
          n.regs.pwmAct = r.regs.pwmSh;
        end
        lbec_pkg::A_TCOMMIT: begin
          n.brStart = powered;
          if (wrData == lbec_pkg::COMMIT_VAL) begin
            n.regs.t0Act = r.regs.t0Sh;
            n.regs.t4Act = r.regs.t4Sh;
            n.regs.trAct = r.regs.trSh;
          end
        end
        lbec_pkg::A_RESET: if (wrData == lbec_pkg::COMMIT_VAL) n.regs = regs_default();
        default: begin
          if (wrAddr >= lbec_pkg::A_PWM0 && wrAddr <= lbec_pkg::A_PWM8)
            n.regs.pwmSh[4'(wrAddr - lbec_pkg::A_PWM0)] = wrData;
          else if (wrAddr >= lbec_pkg::A_T0 && wrAddr <= lbec_pkg::A_T0END)
            n.regs.t0Sh[4'(wrAddr - lbec_pkg::A_T0)] = wrData[5:0];
          else if (wrAddr >= lbec_pkg::A_TR && wrAddr <= lbec_pkg::A_TREND)
            n.regs.trSh[2'(wrAddr - lbec_pkg::A_TR)] = wrData & lbec_pkg::MSK_TR;
          else if (wrAddr >= lbec_pkg::A_T4 && wrAddr <= lbec_pkg::A_T4END)
            n.regs.t4Sh[4'(wrAddr - lbec_pkg::A_T4)] = wrData[5:0];
        end
      endcase
    end
    // Breathing timebase: own divider as master, sync clock edges as slave
    n.fineTick = 1'b0;
    if (slave) begin
      n.fineCnt = 16'h0000;
      n.fineTick = (r.lkS2 != r.lkPrev);
    end else if (r.fineCnt == 16'(FINE_CYC - 1)) begin
      n.fineCnt = 16'h0000;
      n.fineTick = 1'b1;
      n.clkTog = !r.clkTog;
    end else begin
      n.fineCnt = r.fineCnt + 16'h0001;
    end
    // Automatic gain control
    amp = {8'h00, audioIn} * {8'h00, lbec_pkg::gain_mul(r.gain)};
    ampS = amp[15:4];
    n.audLvl = (|ampS[11:8]) ? 8'hff : ampS[7:0];
    if (r.regs.cfg1[lbec_pkg::AGCE_BIT]) begin
      n.gain = r.regs.cfg2[lbec_pkg::AGS_LSB +: 3];
    end else if (r.fineTick) begin
      n.agcDiv = r.agcDiv + 3'h1;
      if (!r.regs.cfg1[lbec_pkg::AGCM_BIT] || r.agcDiv == lbec_pkg::AGC_SLOW_DIV) begin
        if (|ampS[11:8] && r.gain != 3'h0) n.gain = r.gain - 3'h1;
        else if (ampS < lbec_pkg::AGC_QUIET && r.gain != 3'h7) n.gain = r.gain + 3'h1;
      end
    end
    // Breathing marker from the selected channel
    marker_channel_select = r.regs.mark[lbec_pkg::CSS_LSB +: 4];
    if (marker_channel_select <= lbec_pkg::CSS_MAX) begin
      if (riseEnd[marker_channel_select]) n.breathMarkerOut = 1'b0;
      if (fallEnd[marker_channel_select]) n.breathMarkerOut = 1'b1;
    end
    // Shared pins: driven only by the master
    n.pinOe = !slave;
    n.pinOut = r.regs.mark[lbec_pkg::BME_BIT] ? r.breathMarkerOut : r.clkTog;
    n.audOe = !slave;
    n.audOut = (r.pwmCnt < r.audLvl);
    n.currentSel = r.regs.cfg2[lbec_pkg::CS_LSB +: 3];
    // Channel duty generation
    n.pwmCnt = r.pwmCnt + 8'h01;
    for (int i = 0; i < 9; i++) begin
      d = r.regs.cfg1[lbec_pkg::MODE_LSB + i / 3] ? brLvl[i] : r.regs.pwmAct[i];
      if (r.regs.cfg1[lbec_pkg::AE_BIT])
        d = slave ? (r.auS2 ? d : 8'h00) : scale(d, r.audLvl);
      if (r.pwmCnt == 8'hff) n.dutyLat[i] = d;
      n.chanOut[i] = powered && r.regs.onAct[i] && (r.pwmCnt < r.dutyLat[i]);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.regs.onSh <= lbec_pkg::RST_ON;
      r.regs.onAct <= lbec_pkg::RST_ON;
      r.breathMarkerOut <= 1'b1;
      r.hwS1 <= 1'b1;
      r.hwS2 <= 1'b1;
      r.hwPrev <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign syncClockOrMarkerPinOut = r.pinOut;
  assign syncClockOrMarkerPinOe = r.pinOe;
  assign audioCurrentSyncOut = r.audOut;
  assign audioCurrentSyncOe = r.audOe;
  assign chanOut = r.chanOut;
  assign currentSel = r.currentSel;
endmodule
`default_nettype wire

// >>> dv/lbec_checker.sv
// Port checks of the breathing controller
`timescale 1ns/1ps
`default_nettype none
module lbec_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic hwPowerDownN,
  input wire logic syncClockOrMarkerPinOe,
  input wire logic audioCurrentSyncOe,
  input wire logic [8:0] chanOut,
  input wire logic [2:0] currentSel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] hi_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hi_r <= 8'h00;
    end else begin
      hi_r <= chanOut[0] ? hi_r + 8'h01 : 8'h00;
    end
  end
  a_pin_off_hold: assert property (!hwPowerDownN [*5] |-> chanOut == 9'h000)
    else $error("channel on while pin low");
  a_pin_off_fall: assert property ($fell(hwPowerDownN) |-> ##[1:5] chanOut == 9'h000)
    else $error("channels slow to stop");
  a_oe_pair: assert property (syncClockOrMarkerPinOe == audioCurrentSyncOe)
    else $error("sync enables differ");
  a_pwm_gap: assert property (chanOut[0] |-> hi_r != 8'hff)
    else $error("channel high a full period");
  a_sda_drain: assert property (sdaOe |-> !sdaOut)
    else $error("data line driven high");
  a_ack_rise: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data pulled while clock high");
  a_ack_fall: assert property ($fell(sdaOe) |-> !sclIn)
    else $error("data freed while clock high");
  a_sel_quiet: assert property (!$stable(currentSel) |-> !sclIn)
    else $error("current field moved off write");
  c_pin_low: cover property ($fell(hwPowerDownN));
  c_slave: cover property ($fell(syncClockOrMarkerPinOe));
  c_ack: cover property ($rose(sdaOe));
endmodule
`default_nettype wire

// >>> dv/lbec_host.sv
// Register bus host model
`timescale 1ns/1ps
`default_nettype none
module lbec_host (
  input wire logic sys_clk,
  input wire logic sdaOe,
  output logic scl,
  output logic sda
);
  logic drv = 1'b1;
  initial scl = 1'b1;
  assign sda = drv & !sdaOe;
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic edg(input logic c, input logic s);
    scl = c;
    drv = s;
    half();
  endtask
  task automatic bitx(input logic b, output logic r);
    drv = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ak, a);
  endtask
  task automatic start(input logic [7:0] a);
    logic [7:0] q;
    edg(scl, 1'b1);
    edg(1'b1, 1'b1);
    edg(1'b1, 1'b0);
    scl = 1'b0;
    xfer(a, 1'b1, q);
  endtask
  task automatic stop();
    drv = 1'b0;
    half();
    edg(1'b1, 1'b0);
    edg(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    start({lbec_pkg::I2C_ADDR, 1'b0});
    xfer(a, 1'b1, q);
    xfer(v, 1'b1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    start({lbec_pkg::I2C_ADDR, 1'b0});
    xfer(a, 1'b1, v);
    stop();
    start({lbec_pkg::I2C_ADDR, 1'b1});
    xfer(8'hff, 1'b1, v);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> dv/lbec_bench.sv
// Self-checking bench of the breathing controller
`timescale 1ns/1ps
`default_nettype none
module lbec_bench;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic hwPowerDownN = 1'b1;
  logic audFix = 1'b0;
  logic linkClk = 1'b0;
  logic [7:0] audioIn = 8'h00;
  logic scl, sda, sdaOut, sdaOe, pinOut, pinOe, audOut, audOe;
  logic [8:0] chanOut;
  logic [2:0] currentSel;
  logic [7:0] q, d, prev;
  logic [7:0] dv [5];
  int nMismatch = 0;
  int nChecks = 0;
  int nMk = 0;
  int n;
  int na;
  always #20 sys_clk = ~sys_clk;
  always #160 linkClk = ~linkClk;
  always @(negedge sys_clk) audioIn <= audFix ? 8'h80 : 8'($urandom);
  always @(negedge pinOut) nMk++;
  lbec_host host (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sda(sda));
  lbec_top #(.FINE_CYC(4)) dut (.sys_clk(sys_clk), .nrst(nrst), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .hwPowerDownN(hwPowerDownN),
    .syncClockOrMarkerPinIn(pinOe ? pinOut : linkClk), .syncClockOrMarkerPinOut(pinOut),
    .syncClockOrMarkerPinOe(pinOe), .audioCurrentSyncIn(audOe & audOut),
    .audioCurrentSyncOut(audOut), .audioCurrentSyncOe(audOe), .audioIn(audioIn),
    .chanOut(chanOut), .currentSel(currentSel));
  function automatic logic [8:0] expCnt(input logic pwr, input logic [7:0] duty);
    return pwr ? {1'b0, duty} : 9'h000;
  endfunction
  task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
    nChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cnt(input int w);
    repeat (w) @(negedge sys_clk);
    n = 0;
    na = 0;
    repeat (256) @(negedge sys_clk) begin
      n += int'(chanOut[0] === 1'b1);
      na += int'(audOut === 1'b1);
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tcommit(input logic [7:0] v);
    host.wr(lbec_pkg::A_TCOMMIT, v);
    nMk = 0;
    cnt(2000);
  endtask
  initial begin
    #3_000_000;
    nMismatch++;
    endOfTest();
  end
  initial begin
    void'($urandom(704));
    dv = '{8'h00, 8'hff, 8'($urandom), 8'($urandom), 8'h04};
    prev = 8'h00;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    host.rd(lbec_pkg::A_CFG2, q);
    chk("cfg2", {1'b0, lbec_pkg::RST_BYTE}, {1'b0, q});
    host.rd(8'h30, q);
    chk("unmapped", 9'h000, {1'b0, q});
    host.wr(lbec_pkg::A_PD, 8'h01);
    foreach (dv[k]) begin
      host.wr(lbec_pkg::A_PWM0, dv[k]);
      cnt(300);
      chk("shadow", expCnt(1'b1, prev), 9'(n));
      host.wr(lbec_pkg::A_DCOMMIT, lbec_pkg::COMMIT_VAL);
      cnt(300);
      chk("duty", expCnt(1'b1, dv[k]), 9'(n));
      prev = dv[k];
    end
    $display("test duty done");
    host.wr(lbec_pkg::A_PD, 8'h00);
    cnt(300);
    chk("soft off", expCnt(1'b0, prev), 9'(n));
    chk("all off", 9'h000, chanOut);
    host.wr(lbec_pkg::A_PD, 8'h01);
    hwPowerDownN = 1'b0;
    host.rd(lbec_pkg::A_PWM0, q);
    chk("read in off", {1'b0, prev}, {1'b0, q});
    cnt(10);
    chk("pin off", expCnt(1'b0, prev), 9'(n));
    hwPowerDownN = 1'b1;
    cnt(300);
    chk("pin on", expCnt(1'b1, prev), 9'(n));
    audFix = 1'b1;
    host.wr(lbec_pkg::A_CFG1, 8'h06);
    cnt(300);
    chk("audio level", 9'h080, 9'(na));
    chk("audio duty", 9'h002, 9'(n));
    host.wr(lbec_pkg::A_CFG1, 8'h00);
    audFix = 1'b0;
    $display("test power done");
    d = 8'($urandom) & 8'h7f;
    host.wr(lbec_pkg::A_CFG2, d);
    host.rd(lbec_pkg::A_CFG2, q);
    chk("cfg2 rw", {1'b0, d & lbec_pkg::MSK_CFG2}, {1'b0, q});
    chk("current", {6'h00, d[6:4]}, {6'h00, currentSel});
    host.wr(lbec_pkg::A_CFG2, 8'h80);
    chk("slave oe", 9'h000, {8'h00, pinOe});
    host.wr(lbec_pkg::A_CFG2, 8'h00);
    chk("master oe", 9'h001, {8'h00, pinOe});
    $display("test role done");
    for (int t = 0; t < 9; t++) host.wr(lbec_pkg::A_T0 + 8'(t), 8'h00);
    host.wr(lbec_pkg::A_TR, 8'h07);
    host.wr(lbec_pkg::A_MARK, 8'h10);
    host.wr(lbec_pkg::A_CFG1, 8'h10);
    tcommit(lbec_pkg::COMMIT_VAL);
    chk("marker", 9'h001, {8'h00, nMk != 0});
    host.wr(lbec_pkg::A_PD, 8'h00);
    host.wr(lbec_pkg::A_PD, 8'h01);
    cnt(500);
    nMk = 0;
    cnt(2000);
    chk("no restart", 9'h000, {8'h00, nMk != 0});
    chk("idle dark", expCnt(1'b0, prev), 9'(n));
    tcommit(8'h5a);
    chk("restart", 9'h001, {8'h00, nMk != 0});
    host.wr(lbec_pkg::A_RAMP, 8'h10);
    tcommit(lbec_pkg::COMMIT_VAL);
    chk("hold peak", expCnt(1'b1, prev), 9'(n));
    host.wr(lbec_pkg::A_RAMP, 8'h11);
    tcommit(lbec_pkg::COMMIT_VAL);
    chk("hold off", expCnt(1'b0, prev), 9'(n));
    $display("test breathing done");
    endOfTest();
  end
endmodule
bind lbec_top lbec_checker chk (.sys_clk(sys_clk), .nrst(nrst), .sclIn(sclIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .hwPowerDownN(hwPowerDownN),
  .syncClockOrMarkerPinOe(syncClockOrMarkerPinOe), .audioCurrentSyncOe(audioCurrentSyncOe),
  .chanOut(chanOut), .currentSel(currentSel));
`default_nettype wire
